/* hdl/emkp_pkg.sv */
// constants shared by the enclave measurement and key policy block
package emkp_pkg;
    localparam int          EMKP_AW         = 8;
    // register byte offsets
    localparam logic [7:0]  EMKP_CMD        = 8'h00;
    localparam logic [7:0]  EMKP_STATUS     = 8'h04;
    localparam logic [7:0]  EMKP_ATTR       = 8'h08;
    localparam logic [7:0]  EMKP_ISV        = 8'h0C;
    localparam logic [7:0]  EMKP_REQ        = 8'h10;
    localparam logic [7:0]  EMKP_CFGSVN     = 8'h14;
    localparam logic [7:0]  EMKP_HWSVN      = 8'h20;
    localparam logic [7:0]  EMKP_OPND       = 8'h40;
    localparam logic [7:0]  EMKP_RESULT     = 8'h60;
    localparam logic [7:0]  EMKP_CMEAS      = 8'h80;
    localparam logic [7:0]  EMKP_SMEAS      = 8'hA0;
    // leaf codes written to the command register
    localparam logic [3:0]  LEAF_CREATE     = 4'h1;
    localparam logic [3:0]  LEAF_PAGE_ADD   = 4'h2;
    localparam logic [3:0]  LEAF_EXTEND     = 4'h3;
    localparam logic [3:0]  LEAF_SIGNER     = 4'h4;
    localparam logic [3:0]  LEAF_SIGINFO    = 4'h5;
    localparam logic [3:0]  LEAF_INIT       = 4'h6;
    localparam logic [3:0]  LEAF_KEYREQ     = 4'h7;
    localparam logic [3:0]  LEAF_REPORT     = 4'h8;
    localparam logic [3:0]  LEAF_EXIT       = 4'h9;
    // key types in the request register
    localparam logic [2:0]  KEY_SEAL        = 3'h0;
    localparam logic [2:0]  KEY_REPORT      = 3'h1;
    localparam logic [2:0]  KEY_LAUNCH      = 3'h2;
    localparam logic [2:0]  KEY_PROV        = 3'h3;
    localparam logic [2:0]  KEY_PROV_SEAL   = 3'h4;
    // key policy field bit positions
    localparam int          POL_CONTENT     = 0;
    localparam int          POL_SIGNER      = 1;
    localparam int          POL_EXTPROD     = 2;
    localparam int          POL_FAMILY      = 3;
    localparam int          POL_CFGID       = 4;
    localparam int          POL_NOPROD      = 5;
    // attribute and status bit positions
    localparam int          ATTR_LAUNCH     = 0;
    localparam int          ATTR_PROV       = 1;
    localparam int          ATTR_KSS        = 2;
    localparam int          ST_ERROR        = 0;
    localparam int          ST_BUILDING     = 1;
    localparam int          ST_READY        = 2;
    // values after reset
    localparam logic [255:0] HASH_IV        = {8{32'h5A5A_C3C3}};
    localparam logic [255:0] SIGN_IV        = {8{32'h3C3C_A5A5}};
    localparam logic [127:0] HWSVN_RESET    = {16{8'h01}};
    typedef enum logic [2:0]
    {
        ST_EMPTY_S = 3'b001,
        ST_BUILD_S = 3'b010,
        ST_INIT_S  = 3'b100
    } emkp_state_type;
endpackage : emkp_pkg

/* hdl/emkp_top.sv */
// enclave measurement, key policy and report logic behind an apb slave
//
// What this block does
// - two 256-bit measurements kept per enclave
// - content hash state initialised by create leaf
// - page add and extend fold into hash
// - init leaf finalises content measurement field
// - signer measurement digests the signing public key
// - product id and security version from signature
// - extended product and family ids with separation
// - configuration id and version kept at create
// - grant only versions not above own version
// - hardware version compared per component
// - report carries current hardware security version
// - exit leaf modifies no software registers
// - launch token key needs launch attribute
// - provisioning keys need provisioning attribute
// - policy picks content or signer seal binding
// - content seal key needs identical measurement
// - signer seal binds signer, product, version
// - four extra separation policies, one drops product
// - keys deterministic per processor, version, enclave
// - report fills identity, macs with target key
// - target report key equals report mac key; only for requested hardware version HWSVN and policy bits 2 to 4 clear
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
module emkp_top
#(
    parameter logic [255:0] ROOT_KEY = {8{32'h1234_5678}}, // arbitrary value
    parameter logic [127:0] HWSVN    = emkp_pkg::HWSVN_RESET
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [emkp_pkg::EMKP_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr
);
    import emkp_pkg::*;

    // stand-in compression step; the real digest core plugs in here
    function automatic logic [255:0] mix(input logic [255:0] a,
                                         input logic [255:0] b);
        logic [255:0] t;
        t = a ^ {b[196:0], b[255:197]};
        return (t + {t[12:0], t[255:13]}) ^ {a[63:0], b[255:64]};
    endfunction : mix

    // every byte of the requested version must not exceed the current one
    function automatic logic svn_ok(input logic [127:0] req,
                                    input logic [127:0] cur);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 16; i++)
            if (req[i*8 +: 8] > cur[i*8 +: 8])
                ok = 1'b0;
        return ok;
    endfunction : svn_ok

    emkp_state_type state_r;
    logic [255:0]   opnd_r;
    logic [255:0]   result_r;
    logic [255:0]   hash_r;
    logic [255:0]   sign_r;
    logic [255:0]   cmeas_r;
    logic [255:0]   smeas_r;
    logic [255:0]   cfgid_r;
    logic [127:0]   extprod_r;
    logic [127:0]   family_r;
    logic [15:0]    prodid_r;
    logic [15:0]    enclave_security_version_r;
    logic [15:0]    cfgsvn_r;
    logic [2:0]     attr_r;
    logic [31:0]    req_r;
    logic           error_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;

    logic           wr_go;
    logic           rd_go;
    logic           cmd_go;
    logic [3:0]     leaf;
    logic [2:0]     key_type;
    logic [5:0]     policy;
    logic [15:0]    req_svn;
    logic           allowed;
    logic [255:0]   ident;
    logic [255:0]   key_nxt;
    logic [255:0]   rkey_tgt;
    logic [255:0]   mac_nxt;
    logic           mapped;

    // an unmapped or misaligned write completes with an error and no effect
    assign wr_go    = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign rd_go    = psel & penable & ~pready_r & ~pwrite;
    assign cmd_go   = wr_go & (paddr == EMKP_CMD);
    assign leaf     = pwdata[3:0];
    assign key_type = req_r[2:0];
    assign policy   = req_r[9:4];
    assign req_svn  = req_r[31:16];

    // entitlement check; the requested hardware version sits in opnd[127:0]
    always_comb
    begin
        allowed = (state_r == ST_INIT_S)
                  && svn_ok(opnd_r[127:0], HWSVN)
                  && (req_svn <= enclave_security_version_r);
        unique case (key_type)
            KEY_SEAL:
                allowed = allowed && (policy[POL_CONTENT] | policy[POL_SIGNER])
                          && (attr_r[ATTR_KSS] || policy[5:2] == 4'h0);
            KEY_REPORT:    allowed = allowed;
            KEY_LAUNCH:    allowed = allowed && attr_r[ATTR_LAUNCH];
            KEY_PROV,
            KEY_PROV_SEAL: allowed = allowed && attr_r[ATTR_PROV];
            default:       allowed = 1'b0;
        endcase
    end

    // identity mixed into the key; fields gated by the policy field
    always_comb
    begin
        ident = 256'h0;
        if (key_type == KEY_REPORT || policy[POL_CONTENT])
            ident = ident ^ cmeas_r;
        if (key_type != KEY_REPORT && policy[POL_SIGNER])
            ident = ident ^ {smeas_r[255:32],
                             policy[POL_NOPROD] ? 16'h0000 : prodid_r,
                             req_svn};
        if (policy[POL_EXTPROD])
            ident = ident ^ {extprod_r, 128'h0};
        if (policy[POL_FAMILY])
            ident = ident ^ {128'h0, family_r};
        if (policy[POL_CFGID])
            ident = ident ^ mix(cfgid_r, {240'h0, cfgsvn_r});
    end

    // derivation depends only on root, version, type and identity
    assign key_nxt  = mix(mix(ROOT_KEY, {opnd_r[127:0], 125'h0, key_type}),
                          ident);
    // target report key from the target description held in the operand
    assign rkey_tgt = mix(mix(ROOT_KEY, {HWSVN, 125'h0, KEY_REPORT}),
                          opnd_r);
    assign mac_nxt  = mix(rkey_tgt, mix(cmeas_r ^ smeas_r,
                          {HWSVN, prodid_r, enclave_security_version_r, 93'h0, attr_r}));

    // enclave lifecycle and measurement engines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_EMPTY_S;
            hash_r  <= HASH_IV;
            sign_r  <= SIGN_IV;
            cmeas_r <= 256'h0;
            smeas_r <= 256'h0;
            cfgid_r <= 256'h0;
        end
        else if (cmd_go)
        begin
            unique case (leaf)
                LEAF_CREATE:
                begin
                    state_r <= ST_BUILD_S;
                    hash_r  <= HASH_IV;
                    sign_r  <= SIGN_IV;
                    cmeas_r <= 256'h0;
                    smeas_r <= 256'h0;
                    cfgid_r <= attr_r[ATTR_KSS] ? opnd_r : 256'h0;
                end
                LEAF_PAGE_ADD, LEAF_EXTEND:
                    if (state_r == ST_BUILD_S)
                        hash_r <= mix(hash_r,
                                      opnd_r ^ {252'h0, leaf});
                LEAF_SIGNER:
                    if (state_r == ST_BUILD_S)
                        sign_r <= mix(sign_r, opnd_r);
                LEAF_INIT:
                    if (state_r == ST_BUILD_S)
                    begin
                        state_r <= ST_INIT_S;
                        cmeas_r <= mix(hash_r, ~HASH_IV);
                        smeas_r <= mix(sign_r, ~SIGN_IV);
                    end
                default:
                    state_r <= state_r;
            endcase
        end
    end

    // signer-assigned identifiers and configuration version
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            extprod_r <= 128'h0;
            family_r  <= 128'h0;
            prodid_r  <= 16'h0000;
            enclave_security_version_r  <= 16'h0000;
            cfgsvn_r  <= 16'h0000;
        end
        else
        begin
            // create may come from any state, so it is not gated by building
            if (cmd_go && leaf == LEAF_CREATE)
                cfgsvn_r <= attr_r[ATTR_KSS] ? opnd_r[15:0]
                                             : 16'h0000;
            if (state_r == ST_BUILD_S && wr_go && paddr == EMKP_ISV)
            begin
                prodid_r <= pwdata[15:0];
                enclave_security_version_r <= pwdata[31:16];
            end
            if (state_r == ST_BUILD_S && cmd_go && leaf == LEAF_SIGINFO
                && attr_r[ATTR_KSS])
            begin
                extprod_r <= opnd_r[127:0];
                family_r  <= opnd_r[255:128];
            end
        end
    end

    // result buffer and error flag; exit leaves every software view alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_r <= 256'h0;
            error_r  <= 1'b0;
        end
        else if (cmd_go)
        begin
            unique case (leaf)
                LEAF_KEYREQ:
                begin
                    result_r <= allowed ? key_nxt : 256'h0;
                    error_r  <= ~allowed;
                end
                LEAF_REPORT:
                begin
                    result_r <= (state_r == ST_INIT_S) ? mac_nxt : 256'h0;
                    error_r  <= state_r != ST_INIT_S;
                end
                LEAF_EXIT:
                    error_r  <= error_r;
                default:
                    error_r  <= 1'b0;
            endcase
        end
    end

    // plain software-written registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opnd_r <= 256'h0;
            attr_r <= 3'h0;
            req_r  <= 32'h0;
        end
        else if (wr_go)
        begin
            if (paddr[7:5] == EMKP_OPND[7:5])
                opnd_r[paddr[4:2]*32 +: 32] <= pwdata;
            if (paddr == EMKP_ATTR && state_r != ST_INIT_S)
                attr_r <= pwdata[2:0];
            if (paddr == EMKP_REQ)
                req_r <= pwdata;
        end
    end

    // read mux; report version is readable even for an all-zero target
    always_comb
    begin
        prdata_r = 32'h0;
        mapped   = 1'b1;
        unique case (paddr[7:5])
            3'h0:
                unique case (paddr[4:2])
                    3'h0: prdata_r = 32'h0;
                    3'h1: prdata_r = {29'h0, state_r == ST_INIT_S,
                                      state_r == ST_BUILD_S, error_r};
                    3'h2: prdata_r = {29'h0, attr_r};
                    3'h3: prdata_r = {enclave_security_version_r, prodid_r};
                    3'h4: prdata_r = req_r;
                    3'h5: prdata_r = {16'h0, cfgsvn_r};
                    default: mapped = 1'b0;
                endcase
            3'h1:
                if (paddr[4])
                    mapped = 1'b0;
                else
                    prdata_r = HWSVN[paddr[3:2]*32 +: 32];
            3'h2: prdata_r = opnd_r[paddr[4:2]*32 +: 32];
            3'h3: prdata_r = result_r[paddr[4:2]*32 +: 32];
            3'h4: prdata_r = cmeas_r[paddr[4:2]*32 +: 32];
            3'h5: prdata_r = smeas_r[paddr[4:2]*32 +: 32];
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0)
            mapped = 1'b0;
    end

    // one wait state: answer registered so every output is a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready    <= 1'b0;
            prdata    <= 32'h0;
            pslverr   <= 1'b0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= psel & penable & ~pready_r;
            pready    <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            pslverr   <= psel & penable & ~pready_r & ~mapped;
            if (rd_go)
                prdata <= mapped ? prdata_r : 32'h0;
        end
    end

    // report key of the last report aimed at the enclave itself
    logic [255:0] rkey_seen;
    logic         rkey_valid;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rkey_seen  <= 256'h0;
            rkey_valid <= 1'b0;
        end
        else if (cmd_go && leaf == LEAF_CREATE)
            rkey_valid <= 1'b0;
        else if (cmd_go && leaf == LEAF_REPORT && state_r == ST_INIT_S
                 && opnd_r == cmeas_r)
        begin
            rkey_seen  <= rkey_tgt;
            rkey_valid <= 1'b1;
        end
    end

    chk_launch_gated: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ && key_type == KEY_LAUNCH
        && !attr_r[ATTR_LAUNCH] |=> error_r && result_r == 256'h0)
        else $error("launch key leaked without attribute");
    chk_prov_gated: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ && key_type >= KEY_PROV
        && !attr_r[ATTR_PROV] |=> error_r)
        else $error("provisioning key without attribute");
    chk_svn_refused: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ && req_svn > enclave_security_version_r
        |=> error_r && result_r == 256'h0)
        else $error("higher version granted");
    chk_hwsvn_refused: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ && !svn_ok(opnd_r[127:0], HWSVN)
        |=> error_r)
        else $error("newer hardware version granted");
    chk_init_final: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_INIT && state_r == ST_BUILD_S
        |=> state_r == ST_INIT_S && cmeas_r == mix($past(hash_r), ~HASH_IV))
        else $error("content measurement not finalised");
    chk_create_iv: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_CREATE |=> hash_r == HASH_IV ##1 1'b1)
        else $error("hash not initialised on create");
    chk_meas_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_INIT_S && !(cmd_go && leaf == LEAF_CREATE)
        |=> $stable(cmeas_r) && $stable(smeas_r))
        else $error("measurement changed after init");
    chk_exit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_EXIT |=> $stable(result_r) && $stable(opnd_r))
        else $error("exit leaf modified state");
    chk_report_key: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ && key_type == KEY_REPORT && allowed
        && policy == 6'h00 && opnd_r[127:0] == HWSVN && rkey_valid
        |=> result_r == rkey_seen)
        else $error("report key differs from report mac key");
    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
    cov_grant: cover property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_KEYREQ ##1 !error_r);
    cov_report: cover property (@(posedge pclk) disable iff (!presetn)
        cmd_go && leaf == LEAF_REPORT && state_r == ST_INIT_S);
    cov_build: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_BUILD_S ##[1:50] state_r == ST_INIT_S);
endmodule : emkp_top

/* testbench/emkp_sw_model.sv */
// apb master standing in for the software that issues leaf functions
`timescale 1ns/10ps
module emkp_sw_model
(
    input  wire logic                          pclk,
    output logic                               psel,
    output logic                               penable,
    output logic                               pwrite,
    output logic [emkp_pkg::EMKP_AW-1:0]       paddr,
    output logic [31:0]                        pwdata,
    input  wire logic [31:0]                   prdata,
    input  wire logic                          pready,
    input  wire logic                          pslverr
);
    import emkp_pkg::*;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer, entered just past a rising edge; ends one idle cycle on
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // waits as long as it takes; only the bench timeout ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines show the inverse so stale data never matches
        pwdata <= ~wd;
        @(posedge pclk);
    endtask : xfer
endmodule : emkp_sw_model

/* testbench/emkp_top_tb.sv */
// self-checking bench for the enclave measurement and key policy block
`timescale 1ns/10ps
module emkp_top_tb;
    import emkp_pkg::*;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [31:0]  rdat;
    logic         rerr;
    logic [255:0] m1;
    logic [255:0] m2;
    logic [255:0] k1;
    logic [255:0] k2;
    int           num_errors;
    int           checks_done;
    int           cycles;

    emkp_sw_model u_sw (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    emkp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #4 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // the whole run needs a few thousand cycles; this cuts a hang short
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("[FAIL] t=%0t timeout got %h exp %h", $time, 1, 0);
            conclude();
        end
    end

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_sw.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        u_sw.xfer(1'b0, a, 32'h0, rdat, rerr);
    endtask : rd

    task automatic get256(input logic [7:0] base, output logic [255:0] v);
        for (int i = 0; i < 8; i++)
        begin
            rd(base + 8'(4 * i));
            v[32*i +: 32] = rdat;
        end
    endtask : get256

    task automatic leaf(input logic [3:0] c, input logic [255:0] op);
        for (int i = 0; i < 8; i++)
            wr(EMKP_OPND + 8'(4 * i), op[32*i +: 32]);
        wr(EMKP_CMD, {28'h0, c});
    endtask : leaf

    task automatic build(input logic swap, input logic [31:0] attr,
                         output logic [255:0] m);
        leaf(LEAF_CREATE, 256'h0);
        rd(EMKP_STATUS);
        chk(rdat[2:0], 3'b010);
        wr(EMKP_ATTR, attr);
        wr(EMKP_ISV, 32'h0005_0042);
        leaf(LEAF_PAGE_ADD, 256'h1000);
        leaf(LEAF_EXTEND, swap ? 256'hB : 256'hA);
        leaf(LEAF_EXTEND, swap ? 256'hA : 256'hB);
        leaf(LEAF_SIGNER, {8{32'hFACE_0001}});
        leaf(LEAF_INIT, 256'h0);
        get256(EMKP_CMEAS, m);
    endtask : build

    // a refused request must flag error and leave the result all zero
    task automatic keyreq(input logic [2:0] t, input logic [5:0] pol,
                          input logic [15:0] ver, input logic [127:0] hw,
                          input logic fail, output logic [255:0] k);
        wr(EMKP_REQ, {ver, 6'h0, pol, 1'b0, t});
        leaf(LEAF_KEYREQ, {128'h0, hw});
        rd(EMKP_STATUS);
        chk(rdat[ST_ERROR], fail);
        get256(EMKP_RESULT, k);
        chk(k == 256'h0, fail);
    endtask : keyreq

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(EMKP_STATUS);
        chk(rdat, 32'h0);
        rd(8'hFC);
        chk(rerr, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            rd(EMKP_HWSVN + 8'(4 * i));
            chk(rdat, HWSVN_RESET[32*i +: 32]);
        end
        build(1'b0, 32'h3, m1);
        rd(EMKP_STATUS);
        chk(rdat[2:0], 3'b100);
        chk(m1 !== HASH_IV, 1'b1);
        get256(EMKP_SMEAS, k1);
        chk(k1 !== SIGN_IV, 1'b1);
        build(1'b1, 32'h3, m2);
        chk(m2 !== m1, 1'b1);
        build(1'b0, 32'h3, m2);
        chk(m2, m1);
        keyreq(KEY_SEAL, 6'h02, 16'h5, HWSVN_RESET, 1'b0, k1);
        keyreq(KEY_SEAL, 6'h02, 16'h5, HWSVN_RESET, 1'b0, k2);
        chk(k2, k1);
        keyreq(KEY_SEAL, 6'h02, 16'h3, HWSVN_RESET, 1'b0, k2);
        chk(k2 !== k1, 1'b1);
        keyreq(KEY_SEAL, 6'h02, 16'h6, HWSVN_RESET, 1'b1, k2);
        keyreq(KEY_SEAL, 6'h01, 16'h5, HWSVN_RESET, 1'b0, k2);
        chk(k2 !== k1, 1'b1);
        keyreq(KEY_SEAL, 6'h00, 16'h5, HWSVN_RESET, 1'b1, k2);
        keyreq(KEY_SEAL, 6'h06, 16'h5, HWSVN_RESET, 1'b1, k2);
        keyreq(KEY_SEAL, 6'h02, 16'h5, HWSVN_RESET + 128'h1, 1'b1, k2);
        wr(EMKP_CMD, {28'h0, LEAF_EXIT});
        rd(EMKP_STATUS);
        chk(rdat[ST_ERROR], 1'b1);
        keyreq(KEY_SEAL, 6'h02, 16'h5, HWSVN_RESET - 128'h1, 1'b0, k2);
        chk(k2 !== k1, 1'b1);
        for (int t = 2; t < 5; t++)
            keyreq(3'(t), 6'h0, 16'h5, HWSVN_RESET, 1'b0, k2);
        keyreq(3'h5, 6'h0, 16'h5, HWSVN_RESET, 1'b1, k2);
        leaf(LEAF_REPORT, m1);
        get256(EMKP_RESULT, k1);
        chk(k1 !== 256'h0, 1'b1);
        leaf(LEAF_REPORT, m1);
        get256(EMKP_RESULT, k2);
        chk(k2, k1);
        // the current enclave is the report target: its report key must match
        keyreq(KEY_REPORT, 6'h0, 16'h5, HWSVN_RESET, 1'b0, k2);
        leaf(LEAF_REPORT, 256'h0);
        rd(EMKP_STATUS);
        chk(rdat[ST_ERROR], 1'b0);
        build(1'b0, 32'h0, m2);
        for (int t = 2; t < 5; t++)
            keyreq(3'(t), 6'h0, 16'h5, HWSVN_RESET, 1'b1, k2);
        // attributes are frozen once the enclave is initialised
        wr(EMKP_ATTR, 32'h3);
        rd(EMKP_ATTR);
        chk(rdat[1:0], 2'b00);
        // key separation enabled: extra policies granted, dropping product
        build(1'b0, 32'h7, m2);
        keyreq(KEY_SEAL, 6'h06, 16'h5, HWSVN_RESET, 1'b0, k1);
        keyreq(KEY_SEAL, 6'h22, 16'h5, HWSVN_RESET, 1'b0, k2);
        chk(k2 !== k1, 1'b1);
        // configuration version taken at create while separation is on
        leaf(LEAF_CREATE, 256'h9);
        rd(EMKP_CFGSVN);
        chk(rdat, 32'h9);
        conclude();
    end
endmodule : emkp_top_tb
